// ===== hw/bcs_map.svh
// register offsets, field positions, reset values and timing counts of the brake sequencer
`ifndef BCS_MAP_SVH
`define BCS_MAP_SVH

// timing: control clock period and timer tick, both in ns
`define BCS_CLK_NS 5
`define BCS_TICK_NS 10000000
`define BCS_TICK_CYCLES (`BCS_TICK_NS / `BCS_CLK_NS)

// apb byte offsets
`define BCS_OFF_APPLY_FREQ 12'h000
`define BCS_OFF_APPLY_DELAY 12'h004
`define BCS_OFF_APPLY_COND 12'h008
`define BCS_OFF_REL_CURR 12'h00c
`define BCS_OFF_REL_FREQ 12'h010
`define BCS_OFF_REL_DELAY 12'h014
`define BCS_OFF_REL_TORQUE 12'h018
`define BCS_OFF_CHECK_TIME 12'h01c
`define BCS_OFF_MOTOR2 12'h020
`define BCS_OFF_STOP_FREQ 12'h024
`define BCS_OFF_HYST 12'h028
`define BCS_OFF_CTRL 12'h02c
`define BCS_OFF_STATUS 12'h030
`define BCS_OFF_IRQ_STATUS 12'h034
`define BCS_OFF_IRQ_MASK 12'h038

// field positions
`define BCS_COND_SPEED_BIT 0
`define BCS_COND_RUNOFF_BIT 4
`define BCS_CTRL_VEC_BIT 0
`define BCS_CTRL_FCLR_BIT 1
`define BCS_IRQ_REL_BIT 0
`define BCS_IRQ_APPLY_BIT 1
`define BCS_IRQ_FAULT_BIT 2
`define BCS_IRQ_STOP_BIT 3

// reset values
`define BCS_RST_THRESH 16'h0000
`define BCS_RST_COND 5'h00
`define BCS_RST_IRQ 4'h0

`endif

// ===== hw/bcs_pkg.sv
// types shared by the brake control sequencer modules
package bcs_pkg;

    // gray along applied -> released -> relocked
    typedef enum logic [1:0] {
        bcs_st_applied = 2'b00,
        bcs_st_released = 2'b01,
        bcs_st_relocked = 2'b11,
        bcs_st_tripped = 2'b10
    } bcs_state_type;

    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic level;
    } bcs_sync_state_type;

    typedef struct packed {
        logic [15:0] count;
    } bcs_timer_state_type;

    typedef struct packed {
        bcs_state_type st;
        logic rel_out;
        logic fault;
        logic [15:0] apply_freq;
        logic [15:0] apply_delay;
        logic [4:0] cond;
        logic [15:0] rel_curr;
        logic [15:0] rel_freq;
        logic [15:0] rel_delay;
        logic [15:0] rel_torque;
        logic [15:0] check_time;
        logic m2_en;
        logic [15:0] stop_freq;
        logic [15:0] hyst;
        logic vec_sensor;
        logic [3:0] irq_status;
        logic [3:0] irq_mask;
        logic irq;
        logic armed;
        logic stop_seen;
        logic run_prev;
        logic [31:0] tick_cnt;
        logic tick;
        logic [31:0] prdata;
        logic slverr;
    } bcs_top_state_type;

endpackage

// ===== hw/bcs_sync.sv
// three-stage synchroniser with agreement filter for the brake feedback pin
`timescale 1ns/1ps
module bcs_sync (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic async_in,
    output logic sync_out
);
    bcs_pkg::bcs_sync_state_type q;
    bcs_pkg::bcs_sync_state_type n;

    // first stage feeds only the second; level moves when stages two and three agree
    always_comb begin
        n = q;
        n.s1 = async_in;
        n.s2 = q.s1;
        n.s3 = q.s2;
        if (q.s2 == q.s3) begin
            n.level = q.s3;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            q <= '0;
        end else begin
            q <= n;
        end
    end

    assign sync_out = q.level;
endmodule

// ===== hw/bcs_timer.sv
// qualifying timer counting 10 ms ticks, restarting when its condition lapses
`timescale 1ns/1ps
module bcs_timer (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic tick,
    input wire logic run,
    input wire logic [15:0] limit,
    output logic done
);
    bcs_pkg::bcs_timer_state_type q;
    bcs_pkg::bcs_timer_state_type n;

    // saturates at the limit so a long hold never wraps
    always_comb begin
        n = q;
        if (!run) begin
            n.count = 16'h0000;
        end else if (tick && (q.count < limit)) begin
            n.count = q.count + 16'h0001;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            q <= '0;
        end else begin
            q <= n;
        end
    end

    // a zero limit qualifies at once
    assign done = run && (q.count >= limit);
endmodule

// ===== hw/bcs_top.sv
// brake control sequencer: release/apply output, feedback check, apb registers
//
// Overview of operation
// - speed below apply threshold for apply time: apply brake
// - condition bit 0 picks detected or reference speed under sensor vector control
// - condition bit 4 set: apply only while run command is off
// - drive output switched off before timer expires: apply brake at once
// - alarm or coast-to-stop shutdown: apply brake immediately
// - motor 2 selected: brake served only when its select bit is set
// - stop recognised after rising above stop plus hysteresis, then below stop
// - after release then apply, no new release until run toggles off and on
// - brake never released while auto-tuning in stop mode
// - output and feedback disagree while running: fault, trip drive, apply brake
// - disagreement tolerated for programmable check time before the fault
// - release once current, frequency and, under sensor vector control, torque exceed thresholds for release time
//
// The register offsets and register access over APB are this design's own decisions.
`timescale 1ns/1ps
`include "bcs_map.svh"
module bcs_top #(
    parameter int unsigned TICK_CYCLES = `BCS_TICK_CYCLES
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic run_cmd,
    input wire logic drive_output_on,
    input wire logic alarm_trip,
    input wire logic coast_stop,
    input wire logic autotune_active,
    input wire logic motor2_selected,
    input wire logic [15:0] output_freq,
    input wire logic [15:0] output_current,
    input wire logic [15:0] output_torque,
    input wire logic [15:0] detected_speed,
    input wire logic [15:0] reference_speed,
    input wire logic brake_feedback_in,
    output logic brake_release_out,
    output logic brake_fault_alarm,
    output logic irq
);
    bcs_pkg::bcs_top_state_type q;
    bcs_pkg::bcs_top_state_type n;

    logic fb_level;
    logic force_apply;
    logic motor_ok;
    logic run_ok;
    logic [15:0] apply_speed;
    logic apply_run;
    logic apply_done;
    logic rel_run;
    logic rel_done;
    logic mismatch_run;
    logic mismatch_done;
    logic run_rise;
    logic wr_en;
    logic [32:0] rd_word;
    logic [16:0] arm_level;

    // strict threshold compare shared by the apply and release qualifiers
    function automatic logic exceeds(input logic [15:0] value, input logic [15:0] level);
        return value > level;
    endfunction

    // read mux, msb flags a mapped offset
    function automatic logic [32:0] read_reg(
        input logic [11:0] addr,
        input bcs_pkg::bcs_top_state_type s,
        input logic fb
    );
        logic [32:0] r;
        r = {1'b1, 32'h0000_0000};
        unique case (addr)
            `BCS_OFF_APPLY_FREQ: r[15:0] = s.apply_freq;
            `BCS_OFF_APPLY_DELAY: r[15:0] = s.apply_delay;
            `BCS_OFF_APPLY_COND: r[4:0] = s.cond;
            `BCS_OFF_REL_CURR: r[15:0] = s.rel_curr;
            `BCS_OFF_REL_FREQ: r[15:0] = s.rel_freq;
            `BCS_OFF_REL_DELAY: r[15:0] = s.rel_delay;
            `BCS_OFF_REL_TORQUE: r[15:0] = s.rel_torque;
            `BCS_OFF_CHECK_TIME: r[15:0] = s.check_time;
            `BCS_OFF_MOTOR2: r[0] = s.m2_en;
            `BCS_OFF_STOP_FREQ: r[15:0] = s.stop_freq;
            `BCS_OFF_HYST: r[15:0] = s.hyst;
            `BCS_OFF_CTRL: r[`BCS_CTRL_VEC_BIT] = s.vec_sensor;
            `BCS_OFF_STATUS: r[7:0] = {s.st, s.armed, s.stop_seen, fb, s.fault, s.rel_out, s.irq};
            `BCS_OFF_IRQ_STATUS: r[3:0] = s.irq_status;
            `BCS_OFF_IRQ_MASK: r[3:0] = s.irq_mask;
            default: r = {1'b0, 32'h0000_0000};
        endcase
        return r;
    endfunction

    bcs_sync u_fb_sync (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .async_in(brake_feedback_in),
        .sync_out(fb_level)
    );

    // qualifying conditions for the three timers
    assign motor_ok = !motor2_selected || q.m2_en;
    assign force_apply = alarm_trip || coast_stop || !drive_output_on || autotune_active
        || !motor_ok;
    assign run_ok = q.cond[`BCS_COND_RUNOFF_BIT] ? !run_cmd : 1'b1;
    // reference/detected choice only means something with a speed sensor
    assign apply_speed = !q.vec_sensor ? output_freq :
        (q.cond[`BCS_COND_SPEED_BIT] ? reference_speed : detected_speed);
    assign apply_run = (q.st == bcs_pkg::bcs_st_released) && run_ok
        && exceeds(q.apply_freq, apply_speed);
    assign rel_run = (q.st == bcs_pkg::bcs_st_applied) && run_cmd && !force_apply
        && exceeds(output_current, q.rel_curr) && exceeds(output_freq, q.rel_freq)
        && (!q.vec_sensor || exceeds(output_torque, q.rel_torque));
    // only checked while the drive runs; a tripped state needs no further checks
    assign mismatch_run = drive_output_on && (q.st != bcs_pkg::bcs_st_tripped)
        && (q.rel_out != fb_level);
    assign run_rise = run_cmd && !q.run_prev;
    assign wr_en = psel && penable && pwrite;
    assign rd_word = read_reg(paddr, q, fb_level);
    assign arm_level = {1'b0, q.stop_freq} + {1'b0, q.hyst};

    bcs_timer u_apply_timer (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .tick(q.tick),
        .run(apply_run),
        .limit(q.apply_delay),
        .done(apply_done)
    );

    bcs_timer u_rel_timer (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .tick(q.tick),
        .run(rel_run),
        .limit(q.rel_delay),
        .done(rel_done)
    );

    bcs_timer u_check_timer (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .tick(q.tick),
        .run(mismatch_run),
        .limit(q.check_time),
        .done(mismatch_done)
    );

    // next-state logic: tick, stop detect, sequencer, registers, interrupts
    always_comb begin
        logic [3:0] ev;
        logic [3:0] w1c;
        ev = 4'h0;
        w1c = 4'h0;
        n = q;
        n.run_prev = run_cmd;
        // 10 ms tick divider
        n.tick = 1'b0;
        if (q.tick_cnt >= 32'(TICK_CYCLES - 1)) begin
            n.tick_cnt = 32'h0000_0000;
            n.tick = 1'b1;
        end else begin
            n.tick_cnt = q.tick_cnt + 32'h0000_0001;
        end
        // stop recognition arms above stop+hysteresis so small dips near zero do not count
        if (run_rise) begin
            n.stop_seen = 1'b0;
        end
        if ({1'b0, output_freq} > arm_level) begin
            n.armed = 1'b1;
        end else if (q.armed && (output_freq < q.stop_freq)) begin
            n.armed = 1'b0;
            n.stop_seen = 1'b1;
            ev[`BCS_IRQ_STOP_BIT] = 1'b1;
        end
        // sequencer; a mismatch trip overrides everything else
        if (mismatch_done) begin
            n.st = bcs_pkg::bcs_st_tripped;
            ev[`BCS_IRQ_FAULT_BIT] = 1'b1;
        end else begin
            unique case (q.st)
                bcs_pkg::bcs_st_applied: begin
                    if (rel_done && !force_apply) begin
                        n.st = bcs_pkg::bcs_st_released;
                        ev[`BCS_IRQ_REL_BIT] = 1'b1;
                    end
                end
                bcs_pkg::bcs_st_released: begin
                    if (force_apply || apply_done) begin
                        n.st = bcs_pkg::bcs_st_relocked;
                        ev[`BCS_IRQ_APPLY_BIT] = 1'b1;
                    end
                end
                bcs_pkg::bcs_st_relocked: begin
                    if (run_rise) begin
                        n.st = bcs_pkg::bcs_st_applied;
                    end
                end
                bcs_pkg::bcs_st_tripped: begin
                    // clearing the fault still demands a fresh run command
                    if (wr_en && (paddr == `BCS_OFF_CTRL) && pwdata[`BCS_CTRL_FCLR_BIT]) begin
                        n.st = bcs_pkg::bcs_st_relocked;
                    end
                end
            endcase
        end
        n.rel_out = (n.st == bcs_pkg::bcs_st_released);
        n.fault = (n.st == bcs_pkg::bcs_st_tripped);
        // apb setup phase captures read data so prdata comes from flops
        if (psel && !penable) begin
            n.prdata = rd_word[31:0];
            n.slverr = !rd_word[32];
        end
        // apb access phase write
        if (wr_en) begin
            unique case (paddr)
                `BCS_OFF_APPLY_FREQ: n.apply_freq = pwdata[15:0];
                `BCS_OFF_APPLY_DELAY: n.apply_delay = pwdata[15:0];
                `BCS_OFF_APPLY_COND: n.cond = pwdata[4:0];
                `BCS_OFF_REL_CURR: n.rel_curr = pwdata[15:0];
                `BCS_OFF_REL_FREQ: n.rel_freq = pwdata[15:0];
                `BCS_OFF_REL_DELAY: n.rel_delay = pwdata[15:0];
                `BCS_OFF_REL_TORQUE: n.rel_torque = pwdata[15:0];
                `BCS_OFF_CHECK_TIME: n.check_time = pwdata[15:0];
                `BCS_OFF_MOTOR2: n.m2_en = pwdata[0];
                `BCS_OFF_STOP_FREQ: n.stop_freq = pwdata[15:0];
                `BCS_OFF_HYST: n.hyst = pwdata[15:0];
                `BCS_OFF_CTRL: n.vec_sensor = pwdata[`BCS_CTRL_VEC_BIT];
                `BCS_OFF_IRQ_STATUS: w1c = pwdata[3:0];
                `BCS_OFF_IRQ_MASK: n.irq_mask = pwdata[3:0];
                default: ;
            endcase
        end
        // sticky status: a new event wins over a same-cycle clear
        n.irq_status = (q.irq_status & ~w1c) | ev;
        n.irq = |(n.irq_status & n.irq_mask);
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            q <= '0;
            q.st <= bcs_pkg::bcs_st_applied;
            q.apply_freq <= `BCS_RST_THRESH;
            q.apply_delay <= `BCS_RST_THRESH;
            q.cond <= `BCS_RST_COND;
            q.check_time <= `BCS_RST_THRESH;
            q.irq_status <= `BCS_RST_IRQ;
            q.irq_mask <= `BCS_RST_IRQ;
        end else begin
            q <= n;
        end
    end

    // zero-wait slave: access phase always completes in its first cycle
    assign pready = 1'b1;
    assign pslverr = psel && penable && q.slverr;
    assign prdata = q.prdata;
    assign brake_release_out = q.rel_out;
    assign brake_fault_alarm = q.fault;
    assign irq = q.irq;

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);

    a_apply_timer_path: assert property (
        ($fell(brake_release_out) && !$past(force_apply) && !brake_fault_alarm)
            |-> $past(apply_done))
        else $error("brake applied without apply timer or forced cause");
    a_runoff_only_apply: assert property (
        ($fell(brake_release_out) && $past(run_cmd) && $past(q.cond[4]))
            |-> ($past(force_apply) || brake_fault_alarm))
        else $error("brake applied by timer with run on and run-off mode");
    a_output_off_apply: assert property (
        (!drive_output_on && brake_release_out) |=> !brake_release_out)
        else $error("brake not applied after drive output went off");
    a_alarm_coast_apply: assert property (
        (alarm_trip || coast_stop) |=> !brake_release_out)
        else $error("brake not applied after alarm or coast stop");
    a_motor2_gate: assert property (
        (motor2_selected && !q.m2_en) |=> !brake_release_out)
        else $error("brake released for unselected second motor");
    a_stop_recog: assert property (
        $rose(q.stop_seen) |-> ($past(q.armed) && ($past(output_freq) < $past(q.stop_freq))))
        else $error("stop recognised without prior arming");
    a_relock_hold: assert property (
        ($fell(brake_release_out) && !run_rise) ##1 !run_rise [*2] |-> !brake_release_out)
        else $error("brake released again without run toggle");
    a_tune_hold: assert property (
        autotune_active |=> !brake_release_out)
        else $error("brake released during auto-tuning");
    a_fault_applies: assert property (
        $rose(brake_fault_alarm) |-> (!brake_release_out && $past(mismatch_run)))
        else $error("fault without mismatch or with brake released");
    a_check_delay: assert property (
        ($rose(mismatch_run) && (q.check_time != 16'h0000)) |=> !brake_fault_alarm)
        else $error("fault raised before check time could elapse");
    a_release_qual: assert property (
        $rose(brake_release_out) |-> ($past(rel_done) && !$past(force_apply)))
        else $error("brake released without release qualification");
    a_tick_single: assert property (
        (q.tick && (TICK_CYCLES > 1)) |=> !q.tick)
        else $error("tick longer than one cycle");

    // a release edge must never coincide with a cause that forbids it
    a_release_run_on: assert property (
        $rose(brake_release_out) |-> $past(run_cmd))
        else $error("brake released with run command off");
    a_tune_no_rise: assert property (
        $rose(brake_release_out) |-> !$past(autotune_active))
        else $error("brake released during auto-tuning");
    a_coast_no_rise: assert property (
        $rose(brake_release_out) |-> (!$past(alarm_trip) && !$past(coast_stop)))
        else $error("brake released during alarm or coast stop");
    a_fault_sticky: assert property (
        (brake_fault_alarm && !wr_en) |=> brake_fault_alarm)
        else $error("brake fault dropped without a clear");
    // timers forget partial counts so a brief dip never adds up
    a_apply_restart: assert property (
        !apply_run |=> (u_apply_timer.q.count == 16'h0000))
        else $error("apply timer kept its count");
    a_rel_restart: assert property (
        !rel_run |=> (u_rel_timer.q.count == 16'h0000))
        else $error("release timer kept its count");
    a_check_restart: assert property (
        !mismatch_run |=> (u_check_timer.q.count == 16'h0000))
        else $error("check timer kept its count");

    c_release: cover property ($rose(brake_release_out));
    c_timed_apply: cover property (brake_release_out ##1 !brake_release_out && !brake_fault_alarm);
    c_fault: cover property ($rose(brake_fault_alarm));
    c_stop_seen: cover property ($rose(q.stop_seen));
    c_fault_clear: cover property (brake_fault_alarm ##1 !brake_fault_alarm);
endmodule

// ===== dv/bcs_brake_model.sv
// behavioural mechanical brake with its feedback contact
`timescale 1ns/1ps
module bcs_brake_model (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic release_cmd,
    input wire logic stuck,
    input wire logic slow,
    output logic feedback
);
    logic [5:0] lag_q;

    // shoe travel modelled as a short shift line, prompt or slow
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            lag_q <= 6'h00;
        end else begin
            lag_q <= {lag_q[4:0], release_cmd};
        end
    end

    // a seized brake never reports release, which is what trips the drive
    assign feedback = stuck ? 1'b0 : (slow ? lag_q[5] : lag_q[1]);
endmodule

// ===== dv/bcs_top_tb.sv
// self-checking bench for the brake control sequencer
`timescale 1ns/1ps
`include "bcs_map.svh"
module bcs_top_tb;
    logic clk_sys;
    logic rst_n;
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic run_cmd;
    logic [4:0] frc;
    logic [15:0] output_freq;
    logic [15:0] output_current;
    logic [15:0] output_torque;
    logic [15:0] detected_speed;
    logic [15:0] reference_speed;
    logic brake_feedback_in;
    logic brake_release_out;
    logic brake_fault_alarm;
    logic irq;
    logic stuck;
    logic slow;
    int miscompares;
    int checked;
    int i;

    // force causes share one vector so a loop can walk them
    wire logic drive_output_on = ~frc[0];
    wire logic alarm_trip = frc[1];
    wire logic coast_stop = frc[2];
    wire logic autotune_active = frc[3];
    wire logic motor2_selected = frc[4];

    always #2.5 clk_sys = ~clk_sys;

    bcs_top #(.TICK_CYCLES(4)) dut_u (
        .clk_sys(clk_sys), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .run_cmd(run_cmd),
        .drive_output_on(drive_output_on), .alarm_trip(alarm_trip),
        .coast_stop(coast_stop), .autotune_active(autotune_active),
        .motor2_selected(motor2_selected), .output_freq(output_freq),
        .output_current(output_current), .output_torque(output_torque),
        .detected_speed(detected_speed), .reference_speed(reference_speed),
        .brake_feedback_in(brake_feedback_in), .brake_release_out(brake_release_out),
        .brake_fault_alarm(brake_fault_alarm), .irq(irq)
    );

    bcs_brake_model brk_u (
        .clk_sys(clk_sys), .rst_n(rst_n), .release_cmd(brake_release_out),
        .stuck(stuck), .slow(slow), .feedback(brake_feedback_in)
    );

    task results;
        if (miscompares == 0 && checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected %s expected %h seen %h", name, exp, got);
        end
    endtask

    // one apb transfer; request held until pready is seen high
    task apb(input logic [11:0] a, input logic w, input logic [31:0] d,
             output logic [31:0] r, output logic e);
        int n;
        @(posedge clk_sys);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (pready !== 1'b1 && n < 50);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 50) begin
            miscompares++;
            results();
        end
    endtask

    task wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(a, 1'b1, d, r, e);
    endtask

    task rdc(input string name, input logic [11:0] a, input logic [31:0] exp);
        logic [31:0] r;
        logic e;
        apb(a, 1'b0, 32'h0, r, e);
        chk(name, exp, r);
    endtask

    // bounded wait for the release output to reach a level
    task wait_out(input logic e, input int n);
        int k;
        for (k = 0; k < n && brake_release_out !== e; k++) @(negedge clk_sys);
        chk("brake_release_out", {31'h0, e}, {31'h0, brake_release_out});
        if (k >= n) results();
        @(posedge clk_sys); // callers drive on the rising edge
    endtask

    task hold_out(input logic e, input int n);
        repeat (n) begin
            @(negedge clk_sys);
            chk("brake_release_out held", {31'h0, e}, {31'h0, brake_release_out});
        end
        @(posedge clk_sys);
    endtask

    // run command toggled off and on, then release expected
    task go_rel;
        @(posedge clk_sys);
        run_cmd <= 1'b0;
        @(posedge clk_sys);
        run_cmd <= 1'b1;
        wait_out(1'b1, 100);
    endtask

    task t_reset;
        logic [31:0] r;
        logic e;
        rdc("status", `BCS_OFF_STATUS, 32'h20);
        rdc("apply_cond", `BCS_OFF_APPLY_COND, 32'h0);
        wr(`BCS_OFF_STATUS, 32'hffffffff);
        rdc("status ro", `BCS_OFF_STATUS, 32'h20);
        apb(12'h040, 1'b0, 32'h0, r, e);
        chk("unmapped data", 32'h0, r);
        chk("unmapped err", 32'h1, {31'h0, e});
        chk("pready", 32'h1, {31'h0, pready});
    endtask

    task t_release;
        output_current <= 16'h0005;
        run_cmd <= 1'b1;
        hold_out(1'b0, 30);
        output_current <= 16'h0064;
        wait_out(1'b1, 40);
        rdc("irq_status", `BCS_OFF_IRQ_STATUS, 32'h1);
        chk("irq", 32'h1, {31'h0, irq});
        wr(`BCS_OFF_IRQ_STATUS, 32'h1);
        rdc("irq_status clr", `BCS_OFF_IRQ_STATUS, 32'h0);
        chk("irq clr", 32'h0, {31'h0, irq});
    endtask

    task t_apply;
        wr(`BCS_OFF_CTRL, 32'h1);
        wr(`BCS_OFF_APPLY_COND, 32'h1);
        detected_speed <= 16'h000a;
        hold_out(1'b1, 30);
        reference_speed <= 16'h000a;
        hold_out(1'b1, 6);
        reference_speed <= 16'h0064;
        hold_out(1'b1, 20);
        reference_speed <= 16'h000a;
        hold_out(1'b1, 6);
        wait_out(1'b0, 30);
        reference_speed <= 16'h0064;
        detected_speed <= 16'h0064;
        wr(`BCS_OFF_CTRL, 32'h0);
        wr(`BCS_OFF_APPLY_COND, 32'h0);
        rdc("apply irq", `BCS_OFF_IRQ_STATUS, 32'h2);
        wr(`BCS_OFF_IRQ_STATUS, 32'hf);
        hold_out(1'b0, 40);
        go_rel();
    endtask

    task t_runoff;
        wr(`BCS_OFF_APPLY_COND, 32'h10);
        output_freq <= 16'h000a;
        hold_out(1'b1, 40);
        run_cmd <= 1'b0;
        wait_out(1'b0, 40);
        output_freq <= 16'h0064; // run-off mode stays on for the forced applies
    endtask

    task t_force;
        for (i = 0; i < 5; i++) begin
            go_rel();
            frc <= 5'h01 << i;
            repeat (2) @(negedge clk_sys);
            chk("forced apply", 32'h0, {31'h0, brake_release_out});
            hold_out(1'b0, 10);
            @(posedge clk_sys);
            frc <= 5'h00;
        end
        wr(`BCS_OFF_MOTOR2, 32'h1);
        frc <= 5'h10;
        go_rel();
        frc <= 5'h00;
        wr(`BCS_OFF_MOTOR2, 32'h0);
        wr(`BCS_OFF_IRQ_MASK, 32'h0);
        @(negedge clk_sys);
        chk("irq masked", 32'h0, {31'h0, irq});
        wr(`BCS_OFF_IRQ_MASK, 32'hf);
        @(negedge clk_sys);
        chk("irq unmasked", 32'h1, {31'h0, irq});
        wr(`BCS_OFF_IRQ_STATUS, 32'hf);
    endtask

    // seized brake: tolerated for the check time, then a trip
    task t_fault;
        logic [31:0] r;
        logic e;
        int k;
        stuck <= 1'b1;
        repeat (12) begin
            @(negedge clk_sys);
            chk("early fault", 32'h0, {31'h0, brake_fault_alarm});
        end
        for (k = 0; k < 40 && brake_fault_alarm !== 1'b1; k++) @(negedge clk_sys);
        chk("fault", 32'h1, {31'h0, brake_fault_alarm});
        chk("trip apply", 32'h0, {31'h0, brake_release_out});
        apb(`BCS_OFF_IRQ_STATUS, 1'b0, 32'h0, r, e);
        chk("fault irq", 32'h1, {31'h0, r[2]});
        stuck <= 1'b0;
        wr(`BCS_OFF_CTRL, 32'h2);
        @(negedge clk_sys);
        chk("fault clr", 32'h0, {31'h0, brake_fault_alarm});
        wr(`BCS_OFF_IRQ_STATUS, 32'hf);
        slow <= 1'b1;
        go_rel();
        repeat (40) @(negedge clk_sys);
        chk("slow brake", 32'h0, {31'h0, brake_fault_alarm});
    endtask

    task t_stop;
        wr(`BCS_OFF_APPLY_FREQ, 32'h0);
        wr(`BCS_OFF_STOP_FREQ, 32'h32);
        wr(`BCS_OFF_HYST, 32'h14);
        output_freq <= 16'h0028;
        wr(`BCS_OFF_IRQ_STATUS, 32'hf);
        output_freq <= 16'h003c;
        repeat (3) @(posedge clk_sys);
        output_freq <= 16'h0028;
        rdc("no stop", `BCS_OFF_IRQ_STATUS, 32'h0);
        output_freq <= 16'h0050;
        repeat (3) @(posedge clk_sys);
        output_freq <= 16'h0028;
        rdc("stop seen", `BCS_OFF_IRQ_STATUS, 32'h8);
    endtask

    initial begin
        clk_sys = 1'b0;
        rst_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        run_cmd = 1'b0;
        frc = 5'h00;
        output_freq = 16'h0064;
        output_current = 16'h0064;
        output_torque = 16'h0064;
        detected_speed = 16'h0064;
        reference_speed = 16'h0064;
        stuck = 1'b0;
        slow = 1'b0;
        miscompares = 0;
        checked = 0;
        repeat (10) @(posedge clk_sys);
        rst_n <= 1'b1;
        t_reset();
        wr(`BCS_OFF_CHECK_TIME, 32'h5);
        wr(`BCS_OFF_REL_CURR, 32'ha);
        wr(`BCS_OFF_REL_FREQ, 32'ha);
        wr(`BCS_OFF_REL_DELAY, 32'h2);
        wr(`BCS_OFF_REL_TORQUE, 32'h0);
        wr(`BCS_OFF_APPLY_FREQ, 32'h32);
        wr(`BCS_OFF_APPLY_DELAY, 32'h3);
        wr(`BCS_OFF_IRQ_MASK, 32'hf);
        t_release();
        t_apply();
        t_runoff();
        t_force();
        t_fault();
        t_stop();
        results();
    end
endmodule
